// ===== core/uart_pkg.sv
package uart_pkg;

   // Register indices; the byte address of each is four times its index.
   localparam logic [7:0] IDX_DIV_LO = 8'h09;
   localparam logic [7:0] IDX_DIV_HI = 8'h20;
   localparam logic [7:0] IDX_CTRL   = 8'h0b;
   localparam logic [7:0] IDX_DATA   = 8'h0c;
   localparam logic [7:0] IDX_STAT   = 8'h0d;

   localparam int ADDR_W = 10;
   localparam int DIV_W  = 12;
   localparam int DIV_LO_W = 8;
   localparam int DIV_HI_W = 4;
   localparam int DATA_BITS = 8;

   // Control register fields.
   localparam int CTRL_RX_EN_BIT = 0;
   localparam int CTRL_DSS_BIT   = 1;
   localparam int CTRL_TX_EN_BIT = 2;
   localparam int CTRL_W         = 3;

   // Status register fields.
   localparam int STAT_RX_AVAIL_BIT = 0;
   localparam int STAT_FRAME_BIT    = 1;
   localparam int STAT_OVERRUN_BIT  = 2;
   localparam int STAT_TX_BUSY_BIT  = 3;

   // Reset values.
   localparam logic [DIV_LO_W-1:0] RST_DIV_LO = 8'h00;
   localparam logic [DIV_HI_W-1:0] RST_DIV_HI = 4'h0;
   localparam logic [CTRL_W-1:0]   RST_CTRL   = 3'h0;

   // Samples per bit and the first of the three voting samples.
   localparam logic [4:0] SPB_NORMAL   = 5'h10;
   localparam logic [4:0] SPB_DOUBLE   = 5'h08;
   localparam logic [4:0] VOTE_NORMAL  = 5'h08;
   localparam logic [4:0] VOTE_DOUBLE  = 5'h04;

   localparam int RX_BUF_DEPTH = 2;

   typedef struct packed {
      logic                 frame_err;
      logic [DATA_BITS-1:0] data;
   } rx_word_s;

   localparam int RX_WORD_W = $bits(rx_word_s);

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } rx_state_e;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA  = 4'b0100,
      TX_STOP  = 4'b1000
   } tx_state_e;

   // Byte address of a register from its index.
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction

endpackage

// ===== core/baud_tick_gen.sv
module baud_tick_gen
   import uart_pkg::*;
#(
   parameter int DW = DIV_W
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic [DW-1:0] divisor,
   output logic               tick
);

   logic [DW-1:0] cnt_ff;
   logic [DW-1:0] nxt_cnt;
   logic          tick_ff;
   logic          nxt_tick;

   // Down counter reloaded with the divisor, so a tick comes every divisor plus one clocks.
   always_comb
   begin
      if (cnt_ff == '0)
      begin
         nxt_cnt  = divisor;
         nxt_tick = 1'b1;
      end
      else
      begin
         nxt_cnt  = cnt_ff - 1'b1;
         nxt_tick = 1'b0;
      end
   end

   // A lowered divisor takes effect only after the current count runs out.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule

// ===== core/word_buffer.sv
module word_buffer #(
   parameter int W     = 9,
   parameter int DEPTH = 2
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_ff [DEPTH];
   logic [PW-1:0] wr_ff;
   logic [PW-1:0] rd_ff;
   logic [PW:0]   cnt_ff;
   logic [PW-1:0] nxt_wr;
   logic [PW-1:0] nxt_rd;
   logic [PW:0]   nxt_cnt;
   logic          push;
   logic          pop;

   // Pointer and fill-count update; full and empty follow the count exactly.
   always_comb
   begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (push)
      begin
         nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
      begin
         nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop)
      begin
         nxt_cnt = cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage needs no reset; the count guards against reading a stale entry.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];

endmodule

// ===== core/uart_baud_gen_double_speed_rx.sv
module uart_baud_gen_double_speed_rx
   import uart_pkg::*;
(
   input  wire logic                        CLOCK,
   input  wire logic                        RST_N,
   input  wire logic                        PSEL,
   input  wire logic                        PENABLE,
   input  wire logic                        PWRITE,
   input  wire logic [uart_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]                 PWDATA,
   output logic [31:0]                      PRDATA,
   output logic                             PREADY,
   output logic                             PSLVERR,
   input  wire logic                        RXD,
   output logic                             TXD
);

   import uart_pkg::*;

   // Two-of-three vote from the ones seen so far and the last sample.
   function automatic logic vote(input logic [1:0] ones, input logic last);
      vote = ({1'b0, ones} + {2'b00, last}) >= 3'd2;
   endfunction

   logic [DIV_LO_W-1:0] div_lo_ff;
   logic [DIV_LO_W-1:0] nxt_div_lo;
   logic [DIV_HI_W-1:0] div_hi_ff;
   logic [DIV_HI_W-1:0] nxt_div_hi;
   logic [CTRL_W-1:0]   ctrl_ff;
   logic [CTRL_W-1:0]   nxt_ctrl;
   logic                ovr_ff;
   logic                nxt_ovr;
   logic                pready_ff;
   logic                nxt_pready;
   logic                pslverr_ff;
   logic                nxt_pslverr;
   logic [31:0]         prdata_ff;
   logic [31:0]         nxt_prdata;
   logic                capt_valid_ff;
   logic                nxt_capt_valid;

   logic [DIV_W-1:0] divisor;
   logic             tick;
   logic             dss;
   logic [4:0]       spb;
   logic [4:0]       vfirst;
   logic             access;
   logic             done;
   logic             mapped;
   logic [31:0]      rd_mux;
   logic             wr_data;
   logic             pop;
   logic             ovr_set;

   rx_word_s  buf_front;
   logic      buf_out_valid;
   logic      buf_in_ready;

   rx_state_e            rx_state_ff;
   rx_state_e            nxt_rx_state;
   logic [4:0]           rx_cnt_ff;
   logic [4:0]           nxt_rx_cnt;
   logic [1:0]           rx_ones_ff;
   logic [1:0]           nxt_rx_ones;
   logic [2:0]           rx_bit_ff;
   logic [2:0]           nxt_rx_bit;
   logic [DATA_BITS-1:0] rx_shift_ff;
   logic [DATA_BITS-1:0] nxt_rx_shift;
   logic                 rx_pend_ff;
   logic                 nxt_rx_pend;
   rx_word_s             rx_word_ff;
   rx_word_s             nxt_rx_word;
   logic [4:0]           smp;
   logic                 bitval;
   logic                 rx_done;

   tx_state_e            tx_state_ff;
   tx_state_e            nxt_tx_state;
   logic [4:0]           tx_cnt_ff;
   logic [4:0]           nxt_tx_cnt;
   logic [2:0]           tx_bit_ff;
   logic [2:0]           nxt_tx_bit;
   logic [DATA_BITS-1:0] tx_shift_ff;
   logic [DATA_BITS-1:0] nxt_tx_shift;
   logic                 txd_ff;
   logic                 nxt_txd;

   // Divisor and mode decode shared by both directions.
   assign divisor = {div_hi_ff, div_lo_ff};
   assign dss     = ctrl_ff[CTRL_DSS_BIT];
   assign spb     = dss ? SPB_DOUBLE : SPB_NORMAL;
   assign vfirst  = dss ? VOTE_DOUBLE : VOTE_NORMAL;

   baud_tick_gen #(
      .DW      (DIV_W)
   ) u_tick (
      .clk     (CLOCK),
      .rst_n   (RST_N),
      .divisor (divisor),
      .tick    (tick)
   );

   word_buffer #(
      .W         (RX_WORD_W),
      .DEPTH     (RX_BUF_DEPTH)
   ) u_rxbuf (
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .in_valid  (rx_pend_ff),
      .in_ready  (buf_in_ready),
      .in_data   (rx_word_ff),
      .out_valid (buf_out_valid),
      .out_ready (pop),
      .out_data  (buf_front)
   );

   // APB decode; one wait state lets the answer come straight from flip-flops.
   always_comb
   begin
      access  = PSEL && PENABLE;
      done    = access && pready_ff;
      mapped  = 1'b1;
      rd_mux  = 32'h0000_0000;
      unique case (PADDR)
         reg_addr(IDX_DIV_LO): rd_mux = {24'h00_0000, div_lo_ff};
         reg_addr(IDX_DIV_HI): rd_mux = {28'h000_0000, div_hi_ff};
         reg_addr(IDX_CTRL):   rd_mux = {29'h0000_0000, ctrl_ff};
         reg_addr(IDX_DATA):   rd_mux = buf_out_valid ? {24'h00_0000, buf_front.data} : '0;
         reg_addr(IDX_STAT):
         begin
            rd_mux[STAT_RX_AVAIL_BIT] = buf_out_valid;
            rd_mux[STAT_FRAME_BIT]    = buf_out_valid && buf_front.frame_err;
            rd_mux[STAT_OVERRUN_BIT]  = ovr_ff;
            rd_mux[STAT_TX_BUSY_BIT]  = (tx_state_ff != TX_IDLE);
         end
         default:              mapped = 1'b0;
      endcase
      wr_data = done && PWRITE && (PADDR == reg_addr(IDX_DATA));
      pop     = done && !PWRITE && (PADDR == reg_addr(IDX_DATA)) && capt_valid_ff;
   end

   // Register writes land only at the completing edge; the overrun set beats its clear.
   always_comb
   begin
      nxt_pready     = access && !pready_ff;
      nxt_pslverr    = (access && !pready_ff) ? !mapped : 1'b0;
      nxt_prdata     = (access && !pready_ff && !PWRITE) ? rd_mux : prdata_ff;
      nxt_capt_valid = (access && !pready_ff) ? buf_out_valid : capt_valid_ff;
      nxt_div_lo     = div_lo_ff;
      nxt_div_hi     = div_hi_ff;
      nxt_ctrl       = ctrl_ff;
      nxt_ovr        = ovr_ff;
      if (done && PWRITE)
      begin
         if (PADDR == reg_addr(IDX_DIV_LO))
         begin
            nxt_div_lo = PWDATA[DIV_LO_W-1:0];
         end
         if (PADDR == reg_addr(IDX_DIV_HI))
         begin
            nxt_div_hi = PWDATA[DIV_HI_W-1:0];
         end
         if (PADDR == reg_addr(IDX_CTRL))
         begin
            nxt_ctrl = PWDATA[CTRL_W-1:0];
         end
         if ((PADDR == reg_addr(IDX_STAT)) && PWDATA[STAT_OVERRUN_BIT])
         begin
            nxt_ovr = 1'b0;
         end
      end
      if (ovr_set)
      begin
         nxt_ovr = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         div_lo_ff     <= RST_DIV_LO;
         div_hi_ff     <= RST_DIV_HI;
         ctrl_ff       <= RST_CTRL;
         ovr_ff        <= 1'b0;
         pready_ff     <= 1'b0;
         pslverr_ff    <= 1'b0;
         prdata_ff     <= '0;
         capt_valid_ff <= 1'b0;
      end
      else
      begin
         div_lo_ff     <= nxt_div_lo;
         div_hi_ff     <= nxt_div_hi;
         ctrl_ff       <= nxt_ctrl;
         ovr_ff        <= nxt_ovr;
         pready_ff     <= nxt_pready;
         pslverr_ff    <= nxt_pslverr;
         prdata_ff     <= nxt_prdata;
         capt_valid_ff <= nxt_capt_valid;
      end
   end

   // Receiver: a sample count per bit, three-sample vote, then shift.
   always_comb
   begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_cnt   = rx_cnt_ff;
      nxt_rx_ones  = rx_ones_ff;
      nxt_rx_bit   = rx_bit_ff;
      nxt_rx_shift = rx_shift_ff;
      smp          = (rx_cnt_ff >= spb) ? 5'h01 : rx_cnt_ff + 5'h01;
      bitval       = vote(rx_ones_ff, RXD);
      rx_done      = 1'b0;
      if (!ctrl_ff[CTRL_RX_EN_BIT])
      begin
         nxt_rx_state = RX_IDLE;
      end
      else if (tick)
      begin
         unique case (rx_state_ff)
            RX_IDLE:
            begin
               if (!RXD)
               begin
                  nxt_rx_state = RX_START;
                  nxt_rx_cnt   = 5'h01;
                  nxt_rx_ones  = 2'b00;
               end
            end
            RX_START, RX_DATA, RX_STOP:
            begin
               nxt_rx_cnt = smp;
               if ((smp >= vfirst) && (smp < vfirst + 5'h02))
               begin
                  nxt_rx_ones = rx_ones_ff + {1'b0, RXD};
               end
               else if (smp == vfirst + 5'h02)
               begin
                  nxt_rx_ones = 2'b00;
                  if (rx_state_ff == RX_START)
                  begin
                     nxt_rx_state = bitval ? RX_IDLE : RX_DATA;
                     nxt_rx_bit   = 3'h0;
                  end
                  else if (rx_state_ff == RX_DATA)
                  begin
                     nxt_rx_shift = {bitval, rx_shift_ff[DATA_BITS-1:1]};
                     nxt_rx_bit   = rx_bit_ff + 3'h1;
                     if (rx_bit_ff == 3'h7)
                     begin
                        nxt_rx_state = RX_STOP;
                     end
                  end
                  else
                  begin
                     rx_done      = 1'b1;
                     nxt_rx_state = RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Finished words wait in one holding slot; a word finished while it is stuck is lost.
   always_comb
   begin
      nxt_rx_pend = rx_pend_ff && !buf_in_ready;
      nxt_rx_word = rx_word_ff;
      ovr_set     = 1'b0;
      if (rx_done)
      begin
         if (nxt_rx_pend)
         begin
            ovr_set = 1'b1;
         end
         else
         begin
            nxt_rx_pend           = 1'b1;
            nxt_rx_word.data      = rx_shift_ff;
            nxt_rx_word.frame_err = !bitval;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rx_state_ff <= RX_IDLE;
         rx_cnt_ff   <= 5'h00;
         rx_ones_ff  <= 2'b00;
         rx_bit_ff   <= 3'h0;
         rx_shift_ff <= '0;
         rx_pend_ff  <= 1'b0;
         rx_word_ff  <= '0;
      end
      else
      begin
         rx_state_ff <= nxt_rx_state;
         rx_cnt_ff   <= nxt_rx_cnt;
         rx_ones_ff  <= nxt_rx_ones;
         rx_bit_ff   <= nxt_rx_bit;
         rx_shift_ff <= nxt_rx_shift;
         rx_pend_ff  <= nxt_rx_pend;
         rx_word_ff  <= nxt_rx_word;
      end
   end

   // Transmitter: start, eight data bits LSB first, one stop bit.
   always_comb
   begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_cnt   = tx_cnt_ff;
      nxt_tx_bit   = tx_bit_ff;
      nxt_tx_shift = tx_shift_ff;
      nxt_txd      = txd_ff;
      unique case (tx_state_ff)
         TX_IDLE:
         begin
            nxt_txd = 1'b1;
            if (wr_data && ctrl_ff[CTRL_TX_EN_BIT])
            begin
               nxt_tx_state = TX_START;
               nxt_tx_shift = PWDATA[DATA_BITS-1:0];
               nxt_tx_cnt   = 5'h00;
               nxt_txd      = 1'b0;
            end
         end
         TX_START, TX_DATA, TX_STOP:
         begin
            if (tick)
            begin
               nxt_tx_cnt = tx_cnt_ff + 5'h01;
               if (tx_cnt_ff + 5'h01 >= spb)
               begin
                  nxt_tx_cnt = 5'h00;
                  if (tx_state_ff == TX_START)
                  begin
                     nxt_tx_state = TX_DATA;
                     nxt_tx_bit   = 3'h0;
                     nxt_txd      = tx_shift_ff[0];
                  end
                  else if (tx_state_ff == TX_DATA)
                  begin
                     nxt_tx_shift = {1'b0, tx_shift_ff[DATA_BITS-1:1]};
                     nxt_tx_bit   = tx_bit_ff + 3'h1;
                     nxt_txd      = tx_shift_ff[1];
                     if (tx_bit_ff == 3'h7)
                     begin
                        nxt_tx_state = TX_STOP;
                        nxt_txd      = 1'b1;
                     end
                  end
                  else
                  begin
                     nxt_tx_state = TX_IDLE;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_state_ff <= TX_IDLE;
         tx_cnt_ff   <= 5'h00;
         tx_bit_ff   <= 3'h0;
         tx_shift_ff <= '0;
         txd_ff      <= 1'b1;
      end
      else
      begin
         tx_state_ff <= nxt_tx_state;
         tx_cnt_ff   <= nxt_tx_cnt;
         tx_bit_ff   <= nxt_tx_bit;
         tx_shift_ff <= nxt_tx_shift;
         txd_ff      <= nxt_txd;
      end
   end

   // Every output comes straight from a flip-flop, so the bus sees no glitches.
   assign PRDATA  = prdata_ff;
   assign PREADY  = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign TXD     = txd_ff;

endmodule

// ===== dv/uart_baud_checker.sv
module uart_baud_checker
(
   input wire logic                        CLOCK,
   input wire logic                        RST_N,
   input wire logic                        PSEL,
   input wire logic                        PENABLE,
   input wire logic                        PWRITE,
   input wire logic [uart_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0]                 PRDATA,
   input wire logic                        PREADY,
   input wire logic                        PSLVERR,
   input wire logic                        RXD,
   input wire logic                        TXD
);
   timeunit 1ns;
   timeprecision 1ps;
   import uart_pkg::*;
   logic mapped;
   logic rd_done;

   // Decode of the five mapped byte addresses and of a completed read.
   assign mapped = PADDR inside {{IDX_DIV_LO, 2'b00}, {IDX_DIV_HI, 2'b00}, {IDX_CTRL, 2'b00},
                                 {IDX_DATA, 2'b00}, {IDX_STAT, 2'b00}};
   assign rd_done = PREADY && !PWRITE;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_ready_wait;
      PSEL && PENABLE && !PREADY |=> PREADY;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("ready late");
   property p_ready_access;
      PREADY |-> PSEL && PENABLE;
   endproperty
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   property p_err_unmapped;
      PREADY && !mapped |-> PSLVERR;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error on hole");
   property p_err_mapped;
      PREADY && mapped |-> !PSLVERR;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("error on mapped address");
   property p_err_zero;
      rd_done && PSLVERR |-> PRDATA == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("hole read not zero");
   property p_hi_width;
      rd_done && PADDR == {IDX_DIV_HI, 2'b00} |-> PRDATA[31:4] == 28'h0;
   endproperty
   a_hi_width: assert property (p_hi_width) else $error("divisor high too wide");
   property p_lo_width;
      rd_done && PADDR == {IDX_DIV_LO, 2'b00} |-> PRDATA[31:8] == 24'h0;
   endproperty
   a_lo_width: assert property (p_lo_width) else $error("divisor low too wide");
   property p_rdata_hold;
      $changed(PRDATA) |-> rd_done;
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind uart_baud_gen_double_speed_rx uart_baud_checker i_chk (.CLOCK(CLOCK), .RST_N(RST_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));

// ===== dv/serial_sender.sv
module serial_sender
(
   input wire logic clk,
   output logic     line
);
   timeunit 1ns;
   timeprecision 1ps;

   // The line idles high between frames.
   initial line = 1'b1;

   // One 8N1 frame, LSB first; noise flips the fourth sample of each data bit.
   task automatic send(input logic [7:0] d, input int cpb, input logic stp, input logic noise);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int b = 0; b < 10; b++)
         for (int c = 0; c < cpb; c++)
         begin
            @(posedge clk);
            line <= (noise && c == 3 && b > 0 && b < 9) ? ~f[b] : f[b];
         end
      @(posedge clk);
      line <= 1'b1;
   endtask

   // A short low spike that must not be taken as a start bit.
   task automatic glitch(input int n);
      repeat (n)
      begin
         @(posedge clk);
         line <= 1'b0;
      end
      @(posedge clk);
      line <= 1'b1;
   endtask
endmodule

// ===== dv/tb_uart_baud_gen_double_speed_rx.sv
module tb_uart_baud_gen_double_speed_rx;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_pkg::*;
   logic              CLOCK = 1'b0;
   logic              RST_N = 1'b0;
   logic              PSEL = 1'b0;
   logic              PENABLE = 1'b0;
   logic              PWRITE = 1'b0;
   logic [ADDR_W-1:0] PADDR = '0;
   logic [31:0]       PWDATA = '0;
   logic [31:0]       PRDATA;
   logic              PREADY;
   logic              PSLVERR;
   logic              RXD;
   logic              TXD;
   int                bad_count = 0;
   int                checks = 0;
   logic [31:0]       rv;
   logic              er;

   // 200 MHz clock.
   always #2.5 CLOCK = ~CLOCK;

   uart_baud_gen_double_speed_rx i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));
   serial_sender i_far (.clk(CLOCK), .line(RXD));

   task automatic stop_test;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until ready is sampled high.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {idx, 2'b00};
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      // Only the watchdog ends a wait for ready.
      while (PREADY !== 1'b1)
      begin
         @(posedge CLOCK);
      end
      rv = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rv, exp);
   endtask

   // Polls status until a received word is waiting; the watchdog bounds the wait.
   task automatic wait_rx;
      apb(1'b0, IDX_STAT, 32'h0);
      while (rv[STAT_RX_AVAIL_BIT] !== 1'b1)
      begin
         apb(1'b0, IDX_STAT, 32'h0);
      end
   endtask

   // Measures the first high bit after the start bit, then lets the frame end.
   task automatic tx_bit(input int exp);
      int n;
      n = 0;
      while (TXD !== 1'b0)
      begin
         @(posedge CLOCK);
         n++;
      end
      while (TXD !== 1'b1)
      begin
         @(posedge CLOCK);
         n++;
      end
      n = 0;
      while (TXD === 1'b1 && n < 500)
      begin
         @(posedge CLOCK);
         n++;
      end
      chk(n, exp);
      repeat (exp * 10) @(posedge CLOCK);
   endtask

   // Main sequence.
   initial
   begin
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'b1;
      rchk(IDX_DIV_LO, 32'h0);
      rchk(IDX_DIV_HI, 32'h0);
      rchk(IDX_CTRL, 32'h0);
      wr(IDX_DIV_LO, 32'hffff_ffa5);
      wr(IDX_DIV_HI, 32'hffff_fffb);
      rchk(IDX_DIV_LO, 32'ha5);
      rchk(IDX_DIV_HI, 32'hb);
      apb(1'b0, 8'h3f, 32'h0);
      chk({31'h0, er}, 32'h1);
      wr(IDX_DIV_HI, 32'h0);
      // Bit time for both speeds and two divisors, expected from the rate relations.
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_CTRL, (i < 2) ? 32'h7 : 32'h5);
         wr(IDX_DIV_LO, i % 2);
         wr(IDX_DATA, 32'h1);
         tx_bit(((i < 2) ? 8 : 16) * (i % 2 + 1));
      end
      wr(IDX_DIV_LO, 32'h0);
      wr(IDX_CTRL, 32'h3);
      i_far.send(8'h5a, 8, 1'b1, 1'b1);
      wait_rx;
      rchk(IDX_STAT, 32'h1);
      rchk(IDX_DATA, 32'h5a);
      // Spikes of four and one samples are rejected; a false start would show a word.
      i_far.glitch(4);
      // The second spike must not fall on the first one's voting samples.
      repeat (16) @(posedge CLOCK);
      i_far.glitch(1);
      repeat (100) @(posedge CLOCK);
      rchk(IDX_STAT, 32'h0);
      i_far.send(8'h3c, 8, 1'b0, 1'b0);
      wait_rx;
      rchk(IDX_STAT, 32'h3);
      rchk(IDX_DATA, 32'h3c);
      wr(IDX_CTRL, 32'h1);
      i_far.send(8'hc3, 16, 1'b1, 1'b0);
      wait_rx;
      rchk(IDX_DATA, 32'hc3);
      wr(IDX_DIV_LO, 32'h1);
      wr(IDX_CTRL, 32'h3);
      i_far.send(8'h96, 16, 1'b1, 1'b0);
      wait_rx;
      rchk(IDX_DATA, 32'h96);
      // Four unread frames: three are kept in order, the newest is lost.
      wr(IDX_DIV_LO, 32'h0);
      for (int i = 0; i < 4; i++)
         i_far.send(8'(8'h10 + i), 8, 1'b1, 1'b0);
      wait_rx;
      for (int i = 0; i < 3; i++)
         rchk(IDX_DATA, 32'h10 + i);
      rchk(IDX_STAT, 32'h4);
      wr(IDX_STAT, 32'h4);
      rchk(IDX_STAT, 32'h0);
      stop_test;
   end

   // Watchdog against a hung handshake.
   initial
   begin
      repeat (60000) @(posedge CLOCK);
      bad_count++;
      stop_test;
   end
endmodule
